// File: common/tpfs_defs.vh
`ifndef TPFS_DEFS_VH
`define TPFS_DEFS_VH
// print mode / paper class codes
`define TPFS_MODE_AUTO     4'h0
`define TPFS_MODE_NORMAL   4'h1
`define TPFS_MODE_LIGHT1   4'h2
`define TPFS_MODE_HEAVY1   4'h3
`define TPFS_MODE_HEAVY2   4'h4
`define TPFS_MODE_HEAVY3   4'h5
`define TPFS_MODE_GLOSSY1  4'h6
`define TPFS_MODE_GLOSSY2  4'h7
`define TPFS_MODE_GLOSSY3  4'h8
`define TPFS_MODE_GFILM    4'h9
`define TPFS_MODE_ENVELOPE 4'hA
`define TPFS_MODE_TRANSP   4'hB
`define TPFS_MODE_LABEL    4'hC
// feed speed ratio codes
`define TPFS_SPD_FULL      3'h0
`define TPFS_SPD_3Q        3'h1
`define TPFS_SPD_HALF      3'h2
`define TPFS_SPD_THIRD     3'h3
`define TPFS_SPD_TENTH     3'h4
// gloss / thickness sensor levels
`define TPFS_GLOSS_MATTE   2'h0
`define TPFS_GLOSS_GLOSSY  2'h1
`define TPFS_GLOSS_FILM    2'h2
`define TPFS_THICK_LIGHT   3'h0
`define TPFS_THICK_NORMAL  3'h1
`define TPFS_THICK_H1      3'h2
`define TPFS_THICK_H2      3'h3
`define TPFS_THICK_H3      3'h4
`define TPFS_THICK_CLEAR   3'h5
// timing
`define TPFS_CLK_MHZ       50
`define TPFS_SEP_US        2000
`define TPFS_SEP_CYC       (`TPFS_SEP_US * `TPFS_CLK_MHZ)
`define TPFS_LED_US        100
`define TPFS_LED_CYC       (`TPFS_LED_US * `TPFS_CLK_MHZ)
`define TPFS_LED_REF       8'h80
`endif

// File: rtl/tpfs_sequencer.v
// Functional notes
// [R1] no tray paper: notify formatter, hold print until paper sensed
// [R2] print command: reverse pickup motor first, then energise pickup solenoid
// [R3] last-sheet roller motion means one sheet left
// [R4] last-sheet motion notifies formatter before image formation begins
// [R5] leading edge at sync sensor stops registration motor and holds sheet
// [R6] media sensors sampled only while sheet held at registration
// [R7] alignment timing reached restarts registration motor to fuser
// [R8] gloss and thickness results combine into reported paper type
// [R9] simplex, mode transparency, other sensed type: mismatch
// [R10] simplex, mode not auto nor transparency, transparency sensed: mismatch
// [R11] duplex-capable mode in duplex, transparency sensed: mismatch
// [R12] power-on and sleep exit: LED test against reference, flag failure
// [R13] undetectable modes take feed speed from requested print mode
// [R14] normal, light1 full; heavy1 3/4; heavy2 1/2; heavy3 1/3
// [R15] glossy1 3/4; glossy2, label 1/2; glossy3 1/3; film, transparency 1/10; envelope full
// [R16] agreed mode enumeration; speed given as ratio code
`timescale 1ns/1ps
`default_nettype none
`include "tpfs_defs.vh"
module tpfs_sequencer #(
  parameter SEP_CYC = `TPFS_SEP_CYC,
  parameter LED_CYC = `TPFS_LED_CYC
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // formatter side
  input  wire       print_cmd,
  input  wire [3:0] print_mode,
  input  wire       duplex,
  input  wire       sleep_exit,
  output reg        tray_empty,
  output reg        last_sheet,
  output reg  [3:0] paper_type,
  output reg        type_valid,
  output reg        type_mismatch,
  output reg        sensor_fail,
  output reg        busy,
  // mechanics and sensors
  input  wire       tray_paper,
  input  wire       last_roller,
  input  wire       vsync_edge,
  input  wire       image_transfer_belt_align,
  input  wire [1:0] gloss_level,
  input  wire [2:0] thick_level,
  input  wire [7:0] led_intensity,
  output reg        pickup_rev,
  output reg        pickup_sol,
  output reg        reg_motor,
  output reg        media_led,
  output reg  [2:0] feed_speed
);
  localparam S_IDLE  = 3'h0;
  localparam S_SEP   = 3'h1;
  localparam S_PICK  = 3'h2;
  localparam S_HOLD  = 3'h3;
  localparam S_FEED  = 3'h4;
  localparam S_LED   = 3'h5;

  // paper class from the two media sensors
  function [3:0] tpfs_classify;
    input [1:0] g;
    input [2:0] t;
    begin
      if (t == `TPFS_THICK_CLEAR)
        tpfs_classify = `TPFS_MODE_TRANSP;
      else if (g == `TPFS_GLOSS_FILM)
        tpfs_classify = `TPFS_MODE_GFILM;
      else if (g == `TPFS_GLOSS_GLOSSY) begin
        if (t == `TPFS_THICK_H3)
          tpfs_classify = `TPFS_MODE_GLOSSY3;
        else if (t == `TPFS_THICK_H2)
          tpfs_classify = `TPFS_MODE_GLOSSY2;
        else
          tpfs_classify = `TPFS_MODE_GLOSSY1;
      end else if (t == `TPFS_THICK_H1)
        tpfs_classify = `TPFS_MODE_HEAVY1;
      else if (t == `TPFS_THICK_H2)
        tpfs_classify = `TPFS_MODE_HEAVY2;
      else if (t == `TPFS_THICK_H3)
        tpfs_classify = `TPFS_MODE_HEAVY3;
      else
        tpfs_classify = `TPFS_MODE_NORMAL;
    end
  endfunction

  // ratio code per class
  function [2:0] tpfs_speed;
    input [3:0] m;
    begin
      case (m)
        `TPFS_MODE_HEAVY1, `TPFS_MODE_GLOSSY1: tpfs_speed = `TPFS_SPD_3Q;    // see [R14] see [R15]
        `TPFS_MODE_HEAVY2, `TPFS_MODE_GLOSSY2,
        `TPFS_MODE_LABEL:                     tpfs_speed = `TPFS_SPD_HALF;  // see [R14] see [R15]
        `TPFS_MODE_HEAVY3, `TPFS_MODE_GLOSSY3: tpfs_speed = `TPFS_SPD_THIRD; // see [R14] see [R15]
        `TPFS_MODE_GFILM, `TPFS_MODE_TRANSP:   tpfs_speed = `TPFS_SPD_TENTH; // see [R15]
        default:                              tpfs_speed = `TPFS_SPD_FULL;  // see [R14] see [R15]
      endcase
    end
  endfunction

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [31:0] cnt;
  reg  [3:0]  job_mode;
  reg         job_duplex;
  reg         led_pending;
  wire [3:0]  sensed;
  wire        undetectable;
  wire        mis_simplex;
  wire        mis_duplex;

  assign sensed       = tpfs_classify(gloss_level, thick_level); // see [R8]
  assign undetectable = (job_mode == `TPFS_MODE_LIGHT1) || (job_mode == `TPFS_MODE_ENVELOPE) ||
                        (job_mode == `TPFS_MODE_LABEL);
  assign mis_simplex  = ((job_mode == `TPFS_MODE_TRANSP) && (sensed != `TPFS_MODE_TRANSP)) || // see [R9]
                        ((job_mode != `TPFS_MODE_AUTO) && (job_mode != `TPFS_MODE_TRANSP) &&
                         (sensed == `TPFS_MODE_TRANSP));                                   // see [R10]
  // transparency is the one mode that cannot duplex
  assign mis_duplex   = (job_mode != `TPFS_MODE_TRANSP) && (sensed == `TPFS_MODE_TRANSP);  // see [R11]

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (led_pending)
          next_state = S_LED;
        else if (print_cmd && tray_paper)   // see [R1]
          next_state = S_SEP;
      end
      S_SEP: begin
        if (cnt >= SEP_CYC - 1)
          next_state = S_PICK;              // see [R2]
      end
      S_PICK: begin
        if (vsync_edge)
          next_state = S_HOLD;              // see [R5]
      end
      S_HOLD: begin
        if (image_transfer_belt_align)
          next_state = S_FEED;              // see [R7]
      end
      S_FEED: begin
        if (!vsync_edge)
          next_state = S_IDLE;
      end
      S_LED: begin
        if (cnt >= LED_CYC - 1)
          next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state         <= S_IDLE;
      cnt           <= 32'h0;
      job_mode      <= 4'h0;
      job_duplex    <= 1'b0;
      led_pending   <= 1'b1;
      tray_empty    <= 1'b0;
      last_sheet    <= 1'b0;
      paper_type    <= 4'h0;
      type_valid    <= 1'b0;
      type_mismatch <= 1'b0;
      sensor_fail   <= 1'b0;
      busy          <= 1'b0;
      pickup_rev    <= 1'b0;
      pickup_sol    <= 1'b0;
      reg_motor     <= 1'b0;
      media_led     <= 1'b0;
      feed_speed    <= `TPFS_SPD_FULL;
    end else begin
      state <= next_state;
      if (next_state != state)
        cnt <= 32'h0;
      else
        cnt <= cnt + 32'h1;
      tray_empty <= !tray_paper;            // see [R1]
      // roller only turns with a single sheet left
      if (state == S_SEP || state == S_PICK)
        last_sheet <= last_sheet | last_roller; // see [R3] see [R4]
      else if (state == S_IDLE && print_cmd && tray_paper)
        last_sheet <= 1'b0;
      if (sleep_exit)
        led_pending <= 1'b1;                // see [R12]
      else if (state == S_LED)
        led_pending <= 1'b0;
      if (state == S_IDLE && next_state == S_SEP) begin
        job_mode      <= print_mode;        // see [R16]
        job_duplex    <= duplex;
        type_valid    <= 1'b0;
        type_mismatch <= 1'b0;
      end
      busy       <= (next_state != S_IDLE) && (next_state != S_LED);
      pickup_rev <= (next_state == S_SEP) || (next_state == S_PICK); // see [R2]
      pickup_sol <= (next_state == S_PICK); // see [R2]
      reg_motor  <= (next_state == S_PICK) || (next_state == S_FEED); // see [R5] see [R7]
      media_led  <= (next_state == S_LED) || (next_state == S_HOLD);
      if (state == S_HOLD && next_state == S_FEED) begin
        // sample once, at end of hold, when the sheet is still
        paper_type    <= sensed;            // see [R6] see [R8]
        type_valid    <= 1'b1;
        type_mismatch <= job_duplex ? mis_duplex : mis_simplex;
        if (undetectable || job_mode == `TPFS_MODE_AUTO && 1'b0)
          feed_speed <= tpfs_speed(job_mode); // see [R13]
        else
          feed_speed <= tpfs_speed(sensed);
      end
      if (state == S_LED && cnt == LED_CYC - 1)
        sensor_fail <= (led_intensity != `TPFS_LED_REF); // see [R12]
    end
  end
endmodule // tpfs_sequencer
`default_nettype wire

// File: tb/tpfs_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpfs_defs.vh"
module tpfs_checker (
  input wire logic       clk_sys, rst_n, tray_paper, tray_empty, busy, last_roller, last_sheet,
  input wire logic       pickup_rev, pickup_sol, reg_motor, media_led, vsync_edge,
  input wire logic       image_transfer_belt_align, type_valid, type_mismatch,
  input wire logic [3:0] paper_type,
  input wire logic [2:0] feed_speed
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_empty_no_start: assert property (!busy && !tray_paper |=> !busy)
    else $error("job started with empty tray");
  chk_empty_flag: assert property (tray_empty |-> !$past(tray_paper))
    else $error("empty flag without empty tray");
  chk_rev_first: assert property ($rose(pickup_sol) |-> $past(pickup_rev))
    else $error("solenoid before reverse drive");
  chk_edge_hold: assert property ($rose(vsync_edge) && pickup_sol |=> !reg_motor && media_led)
    else $error("sheet not held at leading edge");
  chk_sense_held: assert property (busy && media_led |-> !reg_motor)
    else $error("media sensed while sheet moving");
  chk_align_go: assert property (busy && media_led && image_transfer_belt_align |=> reg_motor && type_valid)
    else $error("no restart at alignment");
  chk_mm_valid: assert property (type_mismatch |-> type_valid)
    else $error("mismatch without paper type");
  chk_last_note: assert property (busy && last_roller |-> ##[1:2] last_sheet)
    else $error("last sheet not reported");
  chk_film_speed: assert property (type_valid && paper_type == `TPFS_MODE_TRANSP |-> feed_speed == `TPFS_SPD_TENTH)
    else $error("transparency not at tenth speed");
endmodule // tpfs_checker
bind tpfs_sequencer tpfs_checker chk_u (.*);
`default_nettype wire

// File: tb/tpfs_formatter.sv
`timescale 1ns/1ps
`default_nettype none
module tpfs_formatter (
  input wire logic       clk_sys, go, busy, dup_in,
  input wire logic [3:0] mode_in,
  output logic           print_cmd, duplex,
  output logic     [3:0] print_mode
);
  initial {print_cmd, duplex, print_mode} = 6'h00;
  // level request held until busy answers; mode and duplex follow their inputs every cycle
  always @(negedge clk_sys) begin
    print_cmd  <= go & !busy;
    print_mode <= mode_in;
    duplex     <= dup_in;
  end
endmodule // tpfs_formatter
`default_nettype wire

// File: tb/test_tpfs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_tpfs_sequencer;
  logic       clk_sys = 1'b0, rst_n = 1'b0, go = 1'b0, dup_in = 1'b0, sleep_exit = 1'b0, tray_paper = 1'b1;
  logic       last_roller = 1'b0, vsync_edge = 1'b0, image_transfer_belt_align = 1'b0;
  logic [3:0] mode_in = 4'h0, print_mode, paper_type;
  logic [1:0] gloss_level = 2'h2;
  logic [2:0] thick_level = 3'h5, feed_speed;
  logic [7:0] led_intensity = 8'h80;
  logic       print_cmd, duplex, tray_empty, last_sheet, type_valid, type_mismatch, sensor_fail, busy;
  logic       pickup_rev, pickup_sol, reg_motor, media_led;
  int         errors = 0, cmp_count = 0;
  typedef struct {logic [3:0] m; logic [1:0] g; logic [2:0] t; logic d; logic [3:0] ty; logic [2:0] sp; logic mm;} tpfs_row_t;
  // type F: not checked, undetectable media
  tpfs_row_t rows [11] = '{'{4'h1,2'h0,3'h1,1'b0,4'h1,3'h0,1'b0}, '{4'h3,2'h0,3'h2,1'b0,4'h3,3'h1,1'b0},
    '{4'h4,2'h0,3'h3,1'b0,4'h4,3'h2,1'b0}, '{4'h5,2'h0,3'h4,1'b0,4'h5,3'h3,1'b0},
    '{4'hB,2'h0,3'h1,1'b0,4'h1,3'h0,1'b1}, '{4'h1,2'h0,3'h5,1'b0,4'hB,3'h4,1'b1},
    '{4'h0,2'h0,3'h5,1'b0,4'hB,3'h4,1'b0}, '{4'h1,2'h0,3'h5,1'b1,4'hB,3'h4,1'b1},
    '{4'hC,2'h0,3'h1,1'b0,4'hF,3'h2,1'b0}, '{4'hA,2'h0,3'h1,1'b0,4'hF,3'h0,1'b0},
    '{4'h2,2'h0,3'h1,1'b0,4'hF,3'h0,1'b0}};
  tpfs_sequencer #(.SEP_CYC(4), .LED_CYC(3)) dut_u (.*);
  tpfs_formatter fmt_u (.*);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v);
    for (int n = 0; n < 50 && s !== v; n++) @(negedge clk_sys);
    check("handshake", {3'h0, v}, {3'h0, s});
  endtask
  task automatic job(input logic [3:0] m, input logic [1:0] g, input logic [2:0] t, input logic d);
    @(negedge clk_sys);
    mode_in = m;
    dup_in = d;
    go = 1'b1;
    wait_for(busy, 1'b1);
    go = 1'b0;
    wait_for(pickup_sol, 1'b1);
    last_roller = 1'b1;
    vsync_edge = 1'b1;
    wait_for(media_led, 1'b1);
    last_roller = 1'b0;
    // true media shown only while held; decoy otherwise
    gloss_level = g;
    thick_level = t;
    repeat (3) @(negedge clk_sys);
    image_transfer_belt_align = 1'b1;
    wait_for(reg_motor, 1'b1);
    gloss_level = 2'h2;
    thick_level = 3'h5;
    @(negedge clk_sys);
    vsync_edge = 1'b0;
    image_transfer_belt_align = 1'b0;
    wait_for(busy, 1'b0);
  endtask
  task automatic summarize;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    check("sensor_fail", 4'h0, {3'h0, sensor_fail});
    tray_paper = 1'b0;
    go = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("busy", 4'h0, {3'h0, busy});
    check("tray_empty", 4'h1, {3'h0, tray_empty});
    go = 1'b0;
    tray_paper = 1'b1;
    foreach (rows[i]) begin
      job(rows[i].m, rows[i].g, rows[i].t, rows[i].d);
      if (rows[i].ty !== 4'hF) check("paper_type", rows[i].ty, paper_type);
      check("feed_speed", {1'b0, rows[i].sp}, {1'b0, feed_speed});
      check("mismatch", {3'h0, rows[i].mm}, {3'h0, type_mismatch});
      check("last_sheet", 4'h1, {3'h0, last_sheet});
    end
    led_intensity = 8'h40;
    sleep_exit = 1'b1;
    @(negedge clk_sys);
    sleep_exit = 1'b0;
    repeat (8) @(negedge clk_sys);
    check("sensor_fail", 4'h1, {3'h0, sensor_fail});
    summarize();
  end
  // jobs take about thirteen cycles each; this is over fifty times the whole run
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule // test_tpfs_sequencer
`default_nettype wire
